//--- tb/pci_command_enable_bits_bench.sv
// Self-checking bench of the command enable bits.
module pci_command_enable_bits_bench;
timeunit 1ns/1ps;
logic clk=0,rst_n=0,cfg_wr,tgt_start=0,tgt_is_mem=0,tgt_is_io=0,bus_idle=1,mst_req=0;
logic tgt_is_palette_wr=0,tgt_is_special=0,mst_want_mwi=0;
logic tgt_claim,pal_snoop,special_take,mst_grant,mst_use_mwi;
logic [31:0] cfg_wdata;
logic [15:0] cmd_rdata;
logic [5:0] cfg_dword;
logic [3:0] cfg_be;
int fails=0,checked=0,cyc=0;
pcmd_host h(.*);
pcmd_command_enable_bits uut(.*);
initial forever #2.5 clk=~clk;
always @(posedge clk) if(++cyc>400) begin fails++; test_done; end
task chk(string n,logic [15:0] s,e); checked++;
if(s!==e) begin fails++; $display("Error %s exp %h saw %h",n,e,s); end endtask
task test_done; $display("fails %0d checked %0d",fails,checked);
if(fails==0&&checked>0) $display("Simulation passed"); else $display("Simulation failed");
$finish; endtask
task cw(logic [15:0] d,logic [5:0] x,logic [3:0] b); @(posedge clk) #1 h.wr(d,x,b); endtask
task acc(logic m,i,p,sp,w); @(posedge clk) #1
{tgt_start,tgt_is_mem,tgt_is_io,tgt_is_palette_wr,tgt_is_special,mst_req,mst_want_mwi}=
{1'b1,m,i,p,sp,1'b1,w};
@(posedge clk) #1 {tgt_start,mst_req}=2'h0; endtask
task t_gate(logic [15:0] v,logic m,w); cw(v|16'hFCA8,6'h01,4'h3);
chk("cmd",cmd_rdata,v);
acc(m,!m,1'b0,1'b1,w);
chk("claim",tgt_claim,m?v[1]:v[0]);
chk("special",special_take,1'b0);
chk("grant",mst_grant,v[2]);
chk("mwi",mst_use_mwi,v[4]&v[2]&w);
$display("t_gate done"); endtask
task t_pal; cw(16'hFFFF,6'h01,4'h3); acc(1'b1,1'b0,1'b1,1'b0,1'b0);
chk("snoop",pal_snoop,1'b0);
chk("palclaim",tgt_claim,1'b1);
$display("t_pal done"); endtask
task t_lane; cw(16'h0000,6'h01,4'h3); cw(16'hFFFF,6'h01,4'h1);
chk("lane0",cmd_rdata,16'h0057);
cw(16'hFFFF,6'h01,4'h2);
chk("lane1",cmd_rdata,16'h0357);
cw(16'h0000,6'h02,4'h3);
chk("index",cmd_rdata,16'h0357);
$display("t_lane done"); endtask
task t_hold; cw(16'h0002,6'h01,4'h3); @(posedge clk) #1 bus_idle=0;
cw(16'h0000,6'h01,4'h3); acc(1'b1,1'b0,1'b0,1'b0,1'b0);
chk("frozen",tgt_claim,1'b1);
@(posedge clk) #1 bus_idle=1; acc(1'b1,1'b0,1'b0,1'b0,1'b0);
chk("detached",tgt_claim,1'b0);
$display("t_hold done"); endtask
task t_rst; cw(16'h0357,6'h01,4'h3); @(posedge clk) #1 rst_n=0;
@(posedge clk) #1 chk("rstcmd",cmd_rdata,16'h0000);
rst_n=1; acc(1'b1,1'b0,1'b0,1'b0,1'b1);
chk("rstclaim",tgt_claim,1'b0);
chk("rstgrant",mst_grant,1'b0);
$display("t_rst done"); endtask
initial begin repeat(16) @(posedge clk); #1 rst_n=1;
chk("reset",cmd_rdata,16'h0000);
t_gate(16'h0357,1'b1,1'b1); t_gate(16'h0355,1'b0,1'b1); t_gate(16'h0012,1'b0,1'b1);
t_gate(16'h0016,1'b1,1'b0); t_gate(16'h0001,1'b1,1'b1); t_gate(16'h0000,1'b1,1'b1);
t_pal; t_lane; t_hold; t_rst; test_done; end
endmodule // pci_command_enable_bits_bench
bind pcmd_command_enable_bits pcmd_sva s(.*);

//--- tb/pcmd_host.sv
// Host bridge model driving command register writes.
module pcmd_host(input logic clk,output logic cfg_wr=0,output logic [5:0] cfg_dword=0,
output logic [3:0] cfg_be=0,output logic [31:0] cfg_wdata=0);
timeunit 1ns;
timeprecision 1ps;
task wr(logic [15:0] d,logic [5:0] x,logic [3:0] b);
{cfg_wr,cfg_dword,cfg_be,cfg_wdata}={1'b1,x,b,16'h0000,d};
@(posedge clk) #1 {cfg_wr,cfg_dword,cfg_be,cfg_wdata}=~{1'b1,x,b,16'h0000,d};
endtask
endmodule // pcmd_host

//--- tb/pcmd_sva.sv
// Checker of the command enable ports.
module pcmd_sva(input logic clk,rst_n,tgt_start,tgt_is_mem,tgt_is_io,bus_idle,tgt_claim,
pal_snoop,special_take,mst_req,mst_grant,mst_use_mwi,input logic [15:0] cmd_rdata);
timeunit 1ns;
timeprecision 1ps;
logic [15:0] p;
logic b;
wire [15:0] c=cmd_rdata;
wire k=b&&p==c,t=tgt_claim,s=tgt_start&&k,q=mst_req&&k,m=tgt_is_mem,i=tgt_is_io;
always_ff @(posedge clk) {p,b}<={c,bus_idle};
default clocking @(posedge clk); endclocking
default disable iff (!rst_n);
AST_MEM: assert property(s&&m&&!i|=>t==$past(c[1])) else $error("mem");
AST_IO: assert property(s&&i&&!m|=>t==$past(c[0])) else $error("io");
AST_MASTER: assert property(q|=>mst_grant==$past(c[2])) else $error("grant");
AST_MWI: assert property(q&&!c[4]|=>!mst_use_mwi) else $error("mwi");
AST_OFF: assert property(k&&c==0|=>!t&&!mst_grant) else $error("detach");
AST_PAL: assert property(pal_snoop|->$past(c[5])) else $error("snoop");
AST_SPECIAL: assert property(special_take|->$past(c[3])) else $error("special");
AST_ONE: assert property(t|->$past(tgt_start)) else $error("claim");
cover property(t&&m);
cover property(t&&i);
cover property(mst_use_mwi);
endmodule // pcmd_sva

//--- verilog/pcmd_command_enable_bits.v
// Command register enable bits and the gating of bus cycles they control.
// How it works
// - Palette snoop bit is masked from writes and stays zero: palette writes are never snooped, always handled as normal.
// - Write-invalidate enable set allows that command; clear forces plain memory write.
// - Special cycle bit is masked from writes and stays zero, so special cycles are always ignored; resets zero.
// - Memory space enable one claims memory accesses; zero gives no response.
// - I/O space enable one claims I/O accesses; zero claims none.
// - Whole register zero: only configuration accesses are answered.
`include "pcmd_map.vh"
module pcmd_command_enable_bits (
   // Clock and reset.
   input wire clk,
   input wire rst_n,
   // Configuration write and read of the command register.
   input wire cfg_wr,
   input wire [5:0] cfg_dword,
   input wire [3:0] cfg_be,
   input wire [31:0] cfg_wdata,
   output reg [15:0] cmd_rdata,
   // Target side: a decoded access starting this cycle.
   input wire tgt_start,
   input wire tgt_is_mem,
   input wire tgt_is_io,
   input wire tgt_is_palette_wr,
   input wire tgt_is_special,
   input wire bus_idle,
   output reg tgt_claim,
   output reg pal_snoop,
   output reg special_take,
   // Master side: request from the function logic.
   input wire mst_req,
   input wire mst_want_mwi,
   output reg mst_grant,
   output reg mst_use_mwi
);
   ////////////////////////////////////////////////////////////////////////////////
   // Register storage and the copy that bus decisions use.
   reg [15:0] cmd;
   reg [15:0] next_cmd;
   reg [15:0] live;
   reg [15:0] next_live;

   // Write decode.
   wire [15:0] wr_mask;
   wire [7:0] mask_lo;
   wire [7:0] mask_hi;
   wire hit;
   wire lane_lo;
   wire lane_hi;

   // Decisions computed for the next edge.
   reg detached;
   reg space_hit;
   reg palette_held;
   reg next_tgt_claim;
   reg next_pal_snoop;
   reg next_special_take;
   reg next_mst_grant;
   reg next_mst_use_mwi;

   ////////////////////////////////////////////////////////////////////////////////
   // Merges one byte lane of a configuration write into the stored value.
   function [7:0] lane_merge;
      input [7:0] old_byte;
      input take;
      input [7:0] wr_byte;
      input [7:0] mask_byte;
      begin
         if (take) begin
            lane_merge = wr_byte & mask_byte;
         end else begin
            lane_merge = old_byte;
         end
      end
   endfunction

   // Reports whether one enable bit of the register copy is set.
   function enable_set;
      input [15:0] word;
      input [3:0] pos;
      begin
         enable_set = word[pos];
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Reserved and read-only bits are masked, so they always read back as zero.
   assign wr_mask = `PCMD_WR_MASK;
   assign mask_lo = wr_mask[7:0];
   assign mask_hi = wr_mask[15:8];
   assign hit = cfg_wr && (cfg_dword == `PCMD_CMD_OFFSET);
   assign lane_lo = hit && cfg_be[0];
   assign lane_hi = hit && cfg_be[1];

   always @* begin
      next_cmd[7:0] = lane_merge(cmd[7:0], lane_lo, cfg_wdata[7:0], mask_lo);
      next_cmd[15:8] = lane_merge(cmd[15:8], lane_hi, cfg_wdata[15:8], mask_hi);
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cmd <= `PCMD_CMD_RESET;
      end else begin
         cmd <= next_cmd;
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cmd_rdata <= `PCMD_CMD_RESET;
      end else begin
         cmd_rdata <= next_cmd;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // The copy is refreshed only between transactions, so a running one keeps its enables.
   always @* begin
      next_live = live;
      if (bus_idle) begin
         next_live = cmd;
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         live <= `PCMD_CMD_RESET;
      end else begin
         live <= next_live;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Target side decisions.
   always @* begin
      detached = (live == 16'h0000);
   end

   always @* begin
      space_hit = 1'b0;
      if (tgt_is_mem && enable_set(live, `PCMD_BIT_MEM)) begin
         space_hit = 1'b1;
      end
      if (tgt_is_io && enable_set(live, `PCMD_BIT_IO)) begin
         space_hit = 1'b1;
      end
   end

   always @* begin
      palette_held = tgt_is_palette_wr && enable_set(live, `PCMD_BIT_PAL);
   end

   always @* begin
      next_tgt_claim = 1'b0;
      if (tgt_start && !detached && space_hit) begin
         next_tgt_claim = 1'b1;
      end
      if (palette_held) begin
         next_tgt_claim = 1'b0;
      end
   end

   always @* begin
      next_pal_snoop = 1'b0;
      if (tgt_start && palette_held) begin
         next_pal_snoop = 1'b1;
      end
   end

   always @* begin
      next_special_take = 1'b0;
      if (tgt_start && tgt_is_special && enable_set(live, `PCMD_BIT_SPECIAL)) begin
         next_special_take = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Master side decisions.
   always @* begin
      next_mst_grant = 1'b0;
      if (mst_req && enable_set(live, `PCMD_BIT_MASTER)) begin
         next_mst_grant = 1'b1;
      end
   end

   always @* begin
      next_mst_use_mwi = 1'b0;
      if (next_mst_grant && mst_want_mwi && enable_set(live, `PCMD_BIT_MWI)) begin
         next_mst_use_mwi = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Every output is registered.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tgt_claim <= 1'b0;
      end else begin
         tgt_claim <= next_tgt_claim;
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pal_snoop <= 1'b0;
      end else begin
         pal_snoop <= next_pal_snoop;
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         special_take <= 1'b0;
      end else begin
         special_take <= next_special_take;
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mst_grant <= 1'b0;
      end else begin
         mst_grant <= next_mst_grant;
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mst_use_mwi <= 1'b0;
      end else begin
         mst_use_mwi <= next_mst_use_mwi;
      end
   end
endmodule // pcmd_command_enable_bits

//--- verilog/pcmd_map.vh
// Offsets, field positions, reset values and masks of the command register.
`ifndef PCMD_MAP_VH
`define PCMD_MAP_VH
`define PCMD_CMD_OFFSET 6'h01
`define PCMD_CMD_RESET 16'h0000
`define PCMD_WR_MASK 16'h0357
`define PCMD_BIT_IO 4'h0
`define PCMD_BIT_MEM 4'h1
`define PCMD_BIT_MASTER 4'h2
`define PCMD_BIT_SPECIAL 4'h3
`define PCMD_BIT_MWI 4'h4
`define PCMD_BIT_PAL 4'h5
`define PCMD_BIT_PER 4'h6
`define PCMD_BIT_SERR 4'h8
`endif
